// >>> include/bizt_pkg.sv
// Package for the bus interface zone timing block.
// Shared register indices (byte address is four times the index), field positions,
// reset values and mode encodings.
package bizt_pkg;
  localparam logic [31:0] ADDR_WRITE_CFG = 32'h00FFF900;
  localparam logic [31:0] ADDR_IO_CFG = 32'h00FFF902;
  localparam logic [31:0] ADDR_SZ0_CFG = 32'h00FFF904;
  localparam logic [31:0] ADDR_SZ1_CFG = 32'h00FFF906;
  localparam logic [31:0] ADDR_SZ2_CFG = 32'h00FFF908;
  localparam logic [31:0] ADDR_STATUS = 32'h00FFF90C;
  localparam logic [7:0] WRITE_CFG_RST = 8'h07;
  localparam logic [15:0] IO_CFG_RST = 16'h069F;
  localparam logic [15:0] SZ_CFG_RST = 16'h069F;
  localparam int EWR_BIT = 0;
  localparam int WAIT_LSB = 0;
  localparam int HOLD_LSB = 3;
  localparam int BW_BIT = 7;
  localparam int POST_ACCESS_IDLE_BIT = 9;
  localparam int FRE_BIT = 11;
  localparam logic [15:0] IO_CFG_MASK = 16'h029F;
  localparam logic [15:0] SZ_CFG_MASK = 16'h0EFF;
  localparam logic [2:0] ENV_IRE = 3'h7;
  localparam logic [2:0] ENV_ERE = 3'h3;
  localparam logic [2:0] ENV_ISP = 3'h6;
  localparam logic [2:0] ENV_DEV = 3'h0;
  localparam logic [23:0] IO_ZONE_BASE = 24'hFFFB00;
  localparam logic [23:0] IO_ZONE_LAST = 24'hFFFBFF;
  localparam logic [23:0] Z0_LAST = 24'h03FFFF;
  localparam logic [23:0] Z0D_BASE = 24'h0E0000;
  localparam logic [23:0] Z0D_LAST = 24'h0E1FFF;
  localparam logic [23:0] Z1_BASE = 24'h400000;
  localparam logic [23:0] Z1_LAST = 24'h7FFFFF;
  localparam logic [23:0] Z2_BASE = 24'h800000;
  localparam logic [23:0] Z2_LAST = 24'hFEFFFF;
  localparam int BASE_READ_CYC = 2;
  localparam int FAST_READ_CYC = 1;
  localparam int LATE_WRITE_CYC = 2;
  localparam int EARLY_WRITE_CYC = 3;
  typedef enum logic [2:0] {
    MODE_IRE, MODE_ERE, MODE_ISP, MODE_DEV, MODE_RSVD
  } bizt_mode_t;
  typedef enum logic [2:0] {
    ZONE_NONE, ZONE_0, ZONE_1, ZONE_2, ZONE_IO
  } bizt_zone_t;
endpackage

// >>> rtl/bizt_env_latch.sv
// Operating environment capture.
// Assumes envPins are asynchronous pins and flashEmpty is a stable level.
`timescale 1ns/1ps
module bizt_env_latch (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Straps
  input wire logic [2:0] envPins,
  input wire logic flashEmpty,
  // Result
  output bizt_pkg::bizt_mode_t mode,
  output logic extEnabled,
  output logic flashMapped
);
  import bizt_pkg::*;
  logic [2:0] envSync1_ff, envSync2_ff;
  logic emptySync1_ff, emptySync2_ff;
  logic [1:0] rstCnt_ff;
  bizt_mode_t mode_ff, nxt_mode;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      envSync1_ff <= 3'h7;
      envSync2_ff <= 3'h7;
      emptySync1_ff <= 1'b0;
      emptySync2_ff <= 1'b0;
    end else begin
      envSync1_ff <= envPins;
      envSync2_ff <= envSync1_ff;
      emptySync1_ff <= flashEmpty;
      emptySync2_ff <= emptySync1_ff;
    end
  end

  // ----------------------------------------
  // Decode and capture after release
  // ----------------------------------------
  always_comb begin
    case (envSync2_ff)
      ENV_IRE: nxt_mode = emptySync2_ff ? MODE_ISP : MODE_IRE;
      ENV_ERE: nxt_mode = emptySync2_ff ? MODE_ISP : MODE_ERE;
      ENV_ISP: nxt_mode = MODE_ISP;
      ENV_DEV: nxt_mode = MODE_DEV;
      default: nxt_mode = MODE_RSVD;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstCnt_ff <= 2'h0;
      mode_ff <= MODE_IRE;
    end else if (rstCnt_ff != 2'h3) begin
      rstCnt_ff <= rstCnt_ff + 2'h1;
      if (rstCnt_ff == 2'h2) begin
        mode_ff <= nxt_mode;
      end
    end
  end

  assign mode = mode_ff;
  assign extEnabled = (mode_ff == MODE_ERE) || (mode_ff == MODE_DEV);
  assign flashMapped = (mode_ff != MODE_DEV);
endmodule

// >>> rtl/bizt_cycle_timer.sv
// Bus cycle length counter.
// Assumes start is a one-cycle pulse taken only while idle.
`timescale 1ns/1ps
module bizt_cycle_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic start,
  input wire logic [3:0] baseCyc,
  input wire logic [2:0] waitCyc,
  input wire logic [1:0] holdCyc,
  input wire logic idleCyc,
  // Phase
  output logic busy,
  output logic inWait,
  output logic inHold,
  output logic done
);
  logic [3:0] baseCnt_ff;
  logic [2:0] waitCnt_ff;
  logic [1:0] holdCnt_ff;
  logic idle_ff, busy_ff, first_ff;

  // ----------------------------------------
  // Phase counters: address, wait, base, hold, idle
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      first_ff <= 1'b0;
      baseCnt_ff <= 4'h0;
      waitCnt_ff <= 3'h0;
      holdCnt_ff <= 2'h0;
      idle_ff <= 1'b0;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      first_ff <= 1'b1;
      baseCnt_ff <= baseCyc - 4'h1;
      waitCnt_ff <= waitCyc;
      holdCnt_ff <= holdCyc;
      idle_ff <= idleCyc;
    end else if (busy_ff) begin
      first_ff <= 1'b0;
      if (!first_ff && waitCnt_ff != 3'h0) begin
        waitCnt_ff <= waitCnt_ff - 3'h1;
      end else if (baseCnt_ff != 4'h0) begin
        baseCnt_ff <= baseCnt_ff - 4'h1;
      end else if (holdCnt_ff != 2'h0) begin
        holdCnt_ff <= holdCnt_ff - 2'h1;
      end else if (idle_ff) begin
        idle_ff <= 1'b0;
      end else begin
        busy_ff <= 1'b0;
      end
    end
  end

  assign busy = busy_ff;
  assign inWait = busy_ff && !first_ff && waitCnt_ff != 3'h0;
  assign inHold = busy_ff && baseCnt_ff == 4'h0 && waitCnt_ff == 3'h0 && holdCnt_ff != 2'h0;
  assign done = busy_ff && baseCnt_ff == 4'h0 && waitCnt_ff == 3'h0 && holdCnt_ff == 2'h0 && !idle_ff
    && !(first_ff && waitCnt_ff != 3'h0);
endmodule

// >>> rtl/bizt_bus_unit.sv
// Bus interface unit: zone decode, cycle timing, config registers over APB.
// Assumes a core bus master that holds a request until its ack pulse.
//
// Overview of operation
// - 111 selects internal ROM, empty gives IN_SYSTEM_PROGRAMMING_MODE
// - 011 selects external ROM, empty gives IN_SYSTEM_PROGRAMMING_MODE
// - 110 always selects in-system programming
// - 000 selects development, flash goes external
// - external space at most 12M bytes
// - normal read two clocks, fast one
// - normal reads after reset
// - late write two, early write three
// - wait cycles follow the address phase
// - hold cycles end the cycle, data kept
// - config bit 0 picks early or late write
// - io wait field adds 0 to 7 waits
// - io hold field adds 0 to 3 holds
// - io width bit, 16-bit default
// - post idle after io zone accesses, before a different zone
// - io config resets to 069Fh, io window
// - fast read ignores wait and hold
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module bizt_bus_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Straps
  input wire logic [2:0] environment_select_pins,
  input wire logic flashEmpty,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core bus
  input wire logic coreReq,
  input wire logic coreWrite,
  input wire logic [23:0] coreAddr,
  input wire logic [15:0] coreWdata,
  output logic coreAck,
  output logic coreErr,
  // Memory side
  output logic [23:0] memAddr,
  output logic [15:0] memWdata,
  output logic memRead,
  output logic memWrite,
  output logic memWide,
  output logic memExternal,
  output logic [2:0] memZone,
  output logic memWaitPhase,
  output logic memHoldPhase,
  output bizt_pkg::bizt_mode_t operatingMode
);
  import bizt_pkg::*;

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  logic [7:0] writeCfg_ff;
  logic [15:0] io_zone_timing_config_ff;
  logic [15:0] szCfg_ff [3];
  logic [23:0] memAddr_ff;
  logic [15:0] memWdata_ff;
  logic memRead_ff;
  logic memWrite_ff;
  logic memWide_ff;
  logic memExt_ff;
  logic coreErr_ff;
  bizt_zone_t curZone_ff;
  bizt_zone_t lastZone_ff;
  bizt_zone_t reqZone;
  logic lastIpst_ff;
  logic extEnabled;
  logic flashMapped;
  logic timerBusy;
  logic timerDone;
  logic inWait;
  logic inHold;
  logic startCycle;
  logic [3:0] baseCyc;
  logic [2:0] waitCyc;
  logic [1:0] holdCyc;
  logic [15:0] zoneCfg;
  logic idleCyc;
  logic fastRead;
  logic badReq;
  logic apbWr;
  logic apbSetup;
  logic reqExternal;
  logic [31:0] statusWord;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic bizt_zone_t zone_of(input logic [23:0] a, input logic flashOn, input logic extOn);
    if (a >= IO_ZONE_BASE && a <= IO_ZONE_LAST) begin
      zone_of = ZONE_IO;
    end else if (a <= Z0_LAST || (a >= Z0D_BASE && a <= Z0D_LAST)) begin
      zone_of = ZONE_0;
    end else if (extOn && a >= Z1_BASE && a <= Z1_LAST) begin
      zone_of = ZONE_1;
    end else if (extOn && a >= Z2_BASE && a <= Z2_LAST) begin
      zone_of = ZONE_2;
    end else begin
      zone_of = ZONE_NONE;
    end
  endfunction

  // ----------------------------------------
  // Register match, one aligned word per index
  // ----------------------------------------
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] reg_addr);
    addr_hit = (a[31:2] == reg_addr[29:0]) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------
  // Environment
  // ----------------------------------------
  bizt_env_latch u_env (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .envPins(environment_select_pins),
    .flashEmpty(flashEmpty),
    .mode(operatingMode),
    .extEnabled(extEnabled),
    .flashMapped(flashMapped)
  );

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  assign pready = 1'b1;
  assign apbWr = psel && penable && pwrite;
  assign apbSetup = psel && !penable;
  assign statusWord = {25'h0000000, timerBusy, curZone_ff, operatingMode};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      writeCfg_ff <= WRITE_CFG_RST;
      io_zone_timing_config_ff <= IO_CFG_RST;
      for (int i = 0; i < 3; i++) begin
        szCfg_ff[i] <= SZ_CFG_RST;
      end
    end else if (apbWr) begin
      if (addr_hit(paddr, ADDR_WRITE_CFG)) begin
        if (pstrb[0]) begin
          writeCfg_ff <= {5'h00, pwdata[2:0]};
        end
      end else if (addr_hit(paddr, ADDR_IO_CFG)) begin
        io_zone_timing_config_ff <= pwdata[15:0] & IO_CFG_MASK;
      end else begin
        for (int i = 0; i < 3; i++) begin
          if (addr_hit(paddr, ADDR_SZ0_CFG + 32'(2 * i))) begin
            szCfg_ff[i] <= pwdata[15:0] & SZ_CFG_MASK;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Register reads, decoded in the setup cycle
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      pslverr <= 1'b0;
      if (addr_hit(paddr, ADDR_WRITE_CFG)) begin
        prdata <= {24'h000000, writeCfg_ff};
      end else if (addr_hit(paddr, ADDR_IO_CFG)) begin
        prdata <= {16'h0000, io_zone_timing_config_ff};
      end else if (addr_hit(paddr, ADDR_SZ0_CFG)) begin
        prdata <= {16'h0000, szCfg_ff[0]};
      end else if (addr_hit(paddr, ADDR_SZ1_CFG)) begin
        prdata <= {16'h0000, szCfg_ff[1]};
      end else if (addr_hit(paddr, ADDR_SZ2_CFG)) begin
        prdata <= {16'h0000, szCfg_ff[2]};
      end else if (addr_hit(paddr, ADDR_STATUS)) begin
        prdata <= statusWord;
      end else begin
        prdata <= 32'h00000000;
        pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Cycle shaping
  // ----------------------------------------
  assign reqZone = zone_of(coreAddr, flashMapped, extEnabled);
  assign badReq = (reqZone == ZONE_NONE);
  assign reqExternal = reqZone == ZONE_1 || reqZone == ZONE_2 || (reqZone == ZONE_0 && !flashMapped);

  // ----------------------------------------
  // Configuration of the addressed zone
  // ----------------------------------------
  always_comb begin
    case (reqZone)
      ZONE_IO: zoneCfg = io_zone_timing_config_ff;
      ZONE_1: zoneCfg = szCfg_ff[1];
      ZONE_2: zoneCfg = szCfg_ff[2];
      default: zoneCfg = szCfg_ff[0];
    endcase
  end

  assign fastRead = !coreWrite && reqZone != ZONE_IO && zoneCfg[FRE_BIT];
  assign idleCyc = 1'b0;

  // ----------------------------------------
  // Basic cycle length
  // ----------------------------------------
  always_comb begin
    if (coreWrite) begin
      baseCyc = writeCfg_ff[EWR_BIT] ? 4'(EARLY_WRITE_CYC) : 4'(LATE_WRITE_CYC);
    end else if (fastRead) begin
      baseCyc = 4'(FAST_READ_CYC);
    end else begin
      baseCyc = 4'(BASE_READ_CYC);
    end
  end

  // ----------------------------------------
  // Wait and hold counts
  // ----------------------------------------
  always_comb begin
    if (fastRead) begin
      waitCyc = 3'h0;
      holdCyc = 2'h0;
    end else begin
      waitCyc = zoneCfg[WAIT_LSB +: 3];
      holdCyc = zoneCfg[HOLD_LSB +: 2];
    end
  end

  // ----------------------------------------
  // Post idle before an access to another zone
  // ----------------------------------------
  logic idlePending;
  logic idleBusy_ff;
  assign idlePending = lastIpst_ff && lastZone_ff != ZONE_NONE && reqZone != lastZone_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idleBusy_ff <= 1'b0;
    end else begin
      idleBusy_ff <= coreReq && !timerBusy && !idleBusy_ff && idlePending && !badReq;
    end
  end

  assign startCycle = coreReq && !timerBusy && !badReq && !(idlePending && !idleBusy_ff);

  // ----------------------------------------
  // Cycle timer
  // ----------------------------------------
  bizt_cycle_timer u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(startCycle),
    .baseCyc(baseCyc),
    .waitCyc(waitCyc),
    .holdCyc(holdCyc),
    .idleCyc(idleCyc),
    .busy(timerBusy),
    .inWait(inWait),
    .inHold(inHold),
    .done(timerDone)
  );

  // ----------------------------------------
  // Memory side, latched at cycle start
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      memAddr_ff <= 24'h000000;
      memWdata_ff <= 16'h0000;
      memRead_ff <= 1'b0;
      memWrite_ff <= 1'b0;
      memWide_ff <= 1'b1;
      memExt_ff <= 1'b0;
      curZone_ff <= ZONE_NONE;
    end else if (startCycle && !timerBusy) begin
      memAddr_ff <= coreAddr;
      memWdata_ff <= coreWdata;
      memRead_ff <= !coreWrite;
      memWrite_ff <= coreWrite;
      memWide_ff <= zoneCfg[BW_BIT];
      memExt_ff <= reqExternal;
      curZone_ff <= reqZone;
    end else if (timerDone) begin
      memRead_ff <= 1'b0;
      memWrite_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Zone history for post idle
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastZone_ff <= ZONE_NONE;
      lastIpst_ff <= 1'b0;
    end else if (timerDone) begin
      lastZone_ff <= curZone_ff;
      lastIpst_ff <= curZone_ff == ZONE_IO ? io_zone_timing_config_ff[POST_ACCESS_IDLE_BIT] : 1'b0;
    end
  end

  // ----------------------------------------
  // Unmapped core access answer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      coreErr_ff <= 1'b0;
    end else begin
      coreErr_ff <= coreReq && !timerBusy && badReq && !coreErr_ff;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign coreAck = timerDone;
  assign coreErr = coreErr_ff;
  assign memAddr = memAddr_ff;
  assign memWdata = memWdata_ff;
  assign memRead = memRead_ff;
  assign memWrite = memWrite_ff;
  assign memWide = memWide_ff;
  assign memExternal = memExt_ff;
  assign memZone = curZone_ff;
  assign memWaitPhase = inWait;
  assign memHoldPhase = inHold;
endmodule

// >>> tb/bizt_chk.sv
// Checker for the core and memory side of the bus unit.
// Assumes it is bound to bizt_bus_unit and sees only its ports.
`timescale 1ns/1ps
module bizt_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Core and memory side
  input wire logic coreAck,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic memWaitPhase,
  input wire logic memHoldPhase,
  input wire logic memExternal,
  input wire logic [2:0] memZone,
  input wire bizt_pkg::bizt_mode_t operatingMode
);
  import bizt_pkg::*;
  logic [2:0] relCnt_ff;
  // ----------------------------------------
  // Edges since reset release
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      relCnt_ff <= 3'h0;
    end else if (relCnt_ff != 3'h4) begin
      relCnt_ff <= relCnt_ff + 3'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  wait_after_addr_a: assert property (memWaitPhase |-> $past(memRead || memWrite) && $stable(memAddr))
    else $error("wait phase before address phase");
  hold_data_a: assert property (memHoldPhase |-> $stable(memWdata) && $stable(memAddr))
    else $error("data moved in hold phase");
  hold_last_a: assert property (memHoldPhase |=> !memWaitPhase)
    else $error("wait phase after hold phase");
  cycle_end_a: assert property (coreAck |-> (memRead || memWrite) ##1 !(memRead || memWrite))
    else $error("ack not at last bus cycle");
  ack_pulse_a: assert property (coreAck |=> !coreAck)
    else $error("ack longer than one cycle");
  write_len_a: assert property ($rose(memWrite) |=> memWrite)
    else $error("write shorter than two cycles");
  mode_kept_a: assert property (relCnt_ff == 3'h4 |=> $stable(operatingMode))
    else $error("mode changed after capture");
  dev_ext_a: assert property (memRead && memZone == 3'h1 && operatingMode == MODE_DEV |-> memExternal)
    else $error("flash region not external");
endmodule
bind bizt_bus_unit bizt_chk chk (
  .core_clk(core_clk), .arst_n(arst_n), .coreAck(coreAck), .memRead(memRead),
  .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memWaitPhase(memWaitPhase),
  .memHoldPhase(memHoldPhase), .memExternal(memExternal), .memZone(memZone),
  .operatingMode(operatingMode)
);

// >>> tb/bizt_core_model.sv
// Core bus master model, one access at a time.
// Assumes calls start just after a clock edge, after mode capture.
`timescale 1ns/1ps
module bizt_core_model (
  // Clock
  input wire logic core_clk,
  // Request
  output logic coreReq,
  output logic coreWrite,
  output logic [23:0] coreAddr,
  output logic [15:0] coreWdata,
  // Answer
  input wire logic coreAck,
  input wire logic coreErr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic memWide,
  input wire logic memExternal
);
  logic ext = 1'b0;
  logic wide = 1'b0;
  logic errSeen = 1'b0;
  initial begin
    coreReq = 1'b0;
    coreWrite = 1'b0;
    coreAddr = 24'h0;
    coreWdata = 16'h0;
  end
  // ----------------------------------------
  // Access, held until ack or error, counts bus cycles
  // ----------------------------------------
  task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] d,
                        output int act, output int lat);
    act = 0;
    lat = 0;
    coreReq <= 1'b1;
    coreWrite <= wr;
    coreAddr <= a;
    coreWdata <= d;
    do begin
      @(posedge core_clk);
      lat++;
      if (memRead || memWrite) begin
        act++;
        ext = memExternal;
        wide = memWide;
      end
    end while (!(coreAck || coreErr));
    errSeen = coreErr;
    coreReq <= 1'b0;
    coreAddr <= ~a;
    coreWdata <= ~d;
    @(posedge core_clk);
  endtask
endmodule

// >>> tb/test_bus_interface_zone_timing.sv
// Self-checking bench for the bus unit.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module test_bus_interface_zone_timing;
  import bizt_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] envPins = 3'h7;
  logic flashEmpty = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, coreReq, coreWrite, coreAck, coreErr, memRead, memWrite, memWide, memExternal;
  logic [23:0] coreAddr;
  logic [15:0] coreWdata;
  bizt_mode_t operatingMode;
  int fails = 0;
  int comparisons = 0;
  int act, lat, lat1;
  logic [31:0] rd;
  logic err;
  logic [2:0] envT [9] = '{3'h7, 3'h7, 3'h3, 3'h3, 3'h6, 3'h6, 3'h5, 3'h0, 3'h0};
  logic fT [9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [2:0] wT [4] = '{3'h0, 3'h7, 3'h0, 3'h5};
  logic [1:0] hT [4] = '{2'h0, 2'h0, 2'h3, 2'h2};
  always #50 core_clk = ~core_clk;
  bizt_bus_unit dut (
    .core_clk(core_clk), .arst_n(arst_n), .environment_select_pins(envPins), .flashEmpty(flashEmpty),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreReq(coreReq), .coreWrite(coreWrite),
    .coreAddr(coreAddr), .coreWdata(coreWdata), .coreAck(coreAck), .coreErr(coreErr), .memAddr(),
    .memWdata(), .memRead(memRead), .memWrite(memWrite), .memWide(memWide), .memExternal(memExternal),
    .memZone(), .memWaitPhase(), .memHoldPhase(), .operatingMode(operatingMode)
  );
  bizt_core_model core (
    .core_clk(core_clk), .coreReq(coreReq), .coreWrite(coreWrite), .coreAddr(coreAddr),
    .coreWdata(coreWdata), .coreAck(coreAck), .coreErr(coreErr), .memRead(memRead),
    .memWrite(memWrite), .memWide(memWide), .memExternal(memExternal)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {a[29:0], 2'h0};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rst(input logic [2:0] e, input logic f);
    arst_n <= 1'b0;
    envPins <= e;
    flashEmpty <= f;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask
  function automatic bizt_mode_t expMode(input logic [2:0] e, input logic f);
    if (e == 3'h6 || (f && (e == 3'h7 || e == 3'h3))) return MODE_ISP;
    if (e == 3'h7) return MODE_IRE;
    if (e == 3'h3) return MODE_ERE;
    return (e == 3'h0) ? MODE_DEV : MODE_RSVD;
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    for (int i = 0; i < 9; i++) begin
      rst(envT[i], fT[i]);
      chk(32'(operatingMode), 32'(expMode(envT[i], fT[i])), "mode");
      envPins <= ~envT[i];
      repeat (4) @(posedge core_clk);
      chk(32'(operatingMode), 32'(expMode(envT[i], fT[i])), "mode kept");
    end
    core.access(1'b0, 24'h000100, 16'h0, act, lat);
    chk({31'h0, core.ext}, 32'h1, "flash region external");
    core.access(1'b1, 24'h7FFFFE, 16'h0, act, lat);
    chk({31'h0, core.ext}, 32'h1, "zone1 external");
    chk(32'(act), 32'd13, "zone1 early write");
    $display("test modes done");
    rst(3'h7, 1'b0);
    apb(1'b0, ADDR_WRITE_CFG, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h07, "write cfg reset");
    apb(1'b0, ADDR_IO_CFG, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h069F, "io cfg reset");
    apb(1'b0, 32'h00FFF920, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    core.access(1'b0, 24'h400000, 16'h0, act, lat);
    chk({31'h0, core.errSeen}, 32'h1, "zone1 refused without external bus");
    chk(32'(act), 32'd0, "no bus cycle on refusal");
    core.access(1'b0, 24'hFFFB10, 16'h0, act, lat);
    chk(32'(act), 32'd12, "default read");
    core.access(1'b1, 24'hFFFB10, 16'hA5C3, act, lat);
    chk(32'(act), 32'd13, "default early write");
    apb(1'b1, ADDR_WRITE_CFG, 32'h06);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_IO_CFG, {16'h0, 16'h0280 | {11'h0, hT[i], wT[i]}});
      core.access(1'b0, 24'hFFFB20, 16'h0, act, lat);
      chk(32'(act), 32'(2 + wT[i] + hT[i]), "io read");
      core.access(1'b1, 24'hFFFBFF, 16'h5A3C, act, lat);
      chk(32'(act), 32'(2 + wT[i] + hT[i]), "io late write");
    end
    apb(1'b0, ADDR_IO_CFG, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h0295, "io cfg readback");
    apb(1'b1, ADDR_WRITE_CFG, 32'h07);
    core.access(1'b1, 24'hFFFB00, 16'h1234, act, lat);
    chk(32'(act), 32'd10, "early write with waits");
    apb(1'b1, ADDR_WRITE_CFG, 32'h06);
    apb(1'b1, ADDR_IO_CFG, 32'h0200);
    core.access(1'b0, 24'hFFFB00, 16'h0, act, lat);
    chk({31'h0, core.wide}, 32'h0, "narrow io bus");
    $display("test timing done");
    apb(1'b1, ADDR_SZ0_CFG, 32'h009F);
    core.access(1'b0, 24'h000100, 16'h0, act, lat);
    chk(32'(act), 32'd12, "zone0 normal read");
    chk({31'h0, core.ext}, 32'h0, "flash internal");
    apb(1'b1, ADDR_SZ0_CFG, 32'h089F);
    core.access(1'b0, 24'h000100, 16'h0, act, lat);
    chk(32'(act), 32'd1, "fast read");
    apb(1'b1, ADDR_IO_CFG, 32'h0280);
    core.access(1'b0, 24'hFFFB00, 16'h0, act, lat);
    chk({31'h0, core.wide}, 32'h1, "wide io bus");
    core.access(1'b0, 24'h000100, 16'h0, act, lat1);
    apb(1'b1, ADDR_IO_CFG, 32'h0080);
    core.access(1'b0, 24'hFFFB00, 16'h0, act, lat);
    core.access(1'b0, 24'h000100, 16'h0, act, lat);
    chk(32'(lat1), 32'(lat + 1), "post idle cycle");
    $display("test fast and idle done");
    print_verdict;
  end
endmodule
